// File: dual_half_timer_core.sv
// dual half timer core: two 16-bit halves or one 32-bit timer / rtc
// assumes synchronous pin inputs and a one-cycle-latency register port
//
// Functional notes
// R1: two 16-bit halves, independent, or joined as 32-bit timer or rtc.
// R2: each half has match, prescale and load registers with control.
// R3: select 0 gives joined 32-bit timer, 1 gives 32-bit rtc.
// R4: 32-bit modes act as one timer; 16-bit halves configure independently.
// R5: 32-bit modes use only even pin; 16-bit uses both pins.
// R6: 32-bit load write splits upper to second half, lower to first.
// R7: 32-bit count read joins second half high, first half low.
// R8: after reset the block is idle, control registers at defaults.
// R9: reset sets both counters and both loads to all ones.
// R10: reset clears both prescale counters and prescale registers.
// R11: trigger sources are ORed; only one timer should drive triggers.
// R12: rtc counts a 32.768 kHz clock on the even pin.
// R13: 32-bit stall freezes counting, except in rtc mode.
// R14: 16-bit timer: one-shot or periodic with 8-bit prescaler.
// R15: each half captures edge counts and edge times on its pin.
// R16: each half gives simple pwm with software output inversion.
// R17: select 4 gives separate 16-bit halves.
// R18: 32-bit count down; at zero reload next cycle, raise time-out.
// R19: one-shot stops at zero and clears run; periodic continues.
// R20: enabled trigger is one pulse in the cycle count hits zero.
// R21: other select values are reserved; counters stay idle.
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module dual_half_timer_core #(
   parameter int RTC_DIV = timer_pkg::RTC_DIV
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire timer_pkg::bus_req_t bus_req,
   output logic [31:0] rdata,
   input wire logic [1:0] ccp_in,
   output logic [1:0] ccp_out,
   output logic [1:0] ccp_oe,
   output logic adc_trig
);
   logic [2:0] cfg_q;
   timer_pkg::block_mode_t mode;
   timer_pkg::half_mode_t amode_q;
   timer_pkg::half_mode_t bmode_q;
   timer_pkg::half_ctl_t actl_q;
   timer_pkg::half_ctl_t bctl_q;
   logic [15:0] aload_q;
   logic [15:0] bload_q;
   logic [15:0] amatch_q;
   logic [15:0] bmatch_q;
   logic [7:0] apre_q;
   logic [7:0] bpre_q;
   logic [4:0] status_q;
   logic [31:0] cnt32_q;
   logic [31:0] rdata_q;
   logic [14:0] rtc_div_q;
   logic rtc_seen_q;
   logic [1:0] ccp_prev_q;
   logic [1:0] rise;
   logic [1:0] fall;
   logic [1:0] edge_hit;
   logic wr_aload;
   logic wr_bload;
   logic wr_ctl;
   logic join32;
   logic rtc;
   logic split;
   logic run32;
   logic to32;
   logic rtc_tick;
   logic rtc_hit;
   logic a_to;
   logic a_ev;
   logic a_done;
   logic a_pwm;
   logic a_done_h;
   logic b_to;
   logic b_ev;
   logic b_done;
   logic b_pwm;
   logic [15:0] a_cnt;
   logic [15:0] a_cap;
   logic [15:0] b_cnt;
   logic [15:0] b_cap;
   logic [4:0] st_set;
   logic [4:0] st_clr;

   // ***************************************
   // block mode decode
   // ***************************************
   always_comb begin
      case (cfg_q)
         // R3: joined and rtc codes
         timer_pkg::CFG_JOIN32: mode = timer_pkg::MODE_JOIN32;
         timer_pkg::CFG_RTC: mode = timer_pkg::MODE_RTC;
         // R17: split halves
         timer_pkg::CFG_SPLIT16: mode = timer_pkg::MODE_SPLIT16;
         // R21: reserved codes idle
         default: mode = timer_pkg::MODE_IDLE;
      endcase
   end

   assign join32 = (mode == timer_pkg::MODE_JOIN32);
   assign rtc = (mode == timer_pkg::MODE_RTC);
   assign split = (mode == timer_pkg::MODE_SPLIT16);
   assign wr_aload = bus_req.we & (bus_req.addr == timer_pkg::OFF_ALOAD);
   assign wr_bload = bus_req.we & (bus_req.addr == timer_pkg::OFF_BLOAD);
   assign wr_ctl = bus_req.we & (bus_req.addr == timer_pkg::OFF_CTL);

   // ***************************************
   // configuration registers
   // ***************************************
   // R2: match and prescale registers
   // R8: control cleared at reset
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cfg_q <= 3'h0;
         amode_q <= '0;
         bmode_q <= '0;
         amatch_q <= 16'h0000;
         bmatch_q <= 16'h0000;
         apre_q <= timer_pkg::PRE_RST;
         bpre_q <= timer_pkg::PRE_RST;
      end else if (bus_req.we) begin
         case (bus_req.addr)
            timer_pkg::OFF_CFG: cfg_q <= bus_req.wdata[2:0];
            timer_pkg::OFF_AMODE: amode_q <= bus_req.wdata[3:0];
            timer_pkg::OFF_BMODE: bmode_q <= bus_req.wdata[3:0];
            timer_pkg::OFF_AMATCH: amatch_q <= bus_req.wdata[15:0];
            timer_pkg::OFF_BMATCH: bmatch_q <= bus_req.wdata[15:0];
            timer_pkg::OFF_APRE: apre_q <= bus_req.wdata[7:0];
            timer_pkg::OFF_BPRE: bpre_q <= bus_req.wdata[7:0];
            default: cfg_q <= cfg_q;
         endcase
      end
   end

   // R9: loads reset to all ones
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         aload_q <= timer_pkg::LOAD_RST;
         bload_q <= timer_pkg::LOAD_RST;
      end else if (wr_aload) begin
         aload_q <= bus_req.wdata[15:0];
         // R6: wide load split
         if (!split) begin
            bload_q <= bus_req.wdata[31:16];
         end
      end else if (wr_bload) begin
         bload_q <= bus_req.wdata[15:0];
      end
   end

   // software write beats the hardware self-clear of run
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         actl_q <= '0;
         bctl_q <= '0;
      end else if (wr_ctl) begin
         actl_q <= bus_req.wdata[5:0];
         bctl_q <= bus_req.wdata[timer_pkg::CTL_B_LSB +: 6];
      end else begin
         // R19: one-shot clears run
         if (a_done) begin
            actl_q.run <= 1'b0;
         end
         if (b_done) begin
            bctl_q.run <= 1'b0;
         end
      end
   end
   // ***************************************
   // pin edges and rtc divider
   // ***************************************
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ccp_prev_q <= 2'h0;
      end else begin
         ccp_prev_q <= ccp_in;
      end
   end

   assign rise = ccp_in & ~ccp_prev_q;
   assign fall = ~ccp_in & ccp_prev_q;

   // R15: edge type select per half
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_edge
         timer_pkg::half_ctl_t c;
         assign c = (gi == 0) ? actl_q : bctl_q;
         assign edge_hit[gi] = (c.evt == timer_pkg::EVT_RISE) ? rise[gi] :
                               (c.evt == timer_pkg::EVT_FALL) ? fall[gi] :
                               (c.evt == timer_pkg::EVT_BOTH) ? (rise[gi] | fall[gi]) : 1'b0;
      end
   endgenerate

   // R12: divide the even pin clock down to seconds
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rtc_div_q <= 15'h0000;
      end else if (!rtc || !actl_q.run) begin
         rtc_div_q <= 15'h0000;
      end else if (rise[0]) begin
         rtc_div_q <= rtc_tick ? 15'h0000 : rtc_div_q + 15'h0001;
      end
   end
   assign rtc_tick = rise[0] & (rtc_div_q == 15'(RTC_DIV - 1));

   // ***************************************
   // joined 32-bit counter
   // ***************************************
   // R13: stall honoured outside rtc only
   assign run32 = actl_q.run & ~actl_q.stall;
   assign to32 = join32 & run32 & (cnt32_q == 32'h0000_0000);
   assign rtc_hit = rtc & actl_q.run & rtc_tick & (cnt32_q == {bmatch_q, amatch_q});

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rtc_seen_q <= 1'b0;
      end else begin
         rtc_seen_q <= rtc;
      end
   end

   // R9: joined count resets all ones
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cnt32_q <= {timer_pkg::COUNT_RST, timer_pkg::COUNT_RST};
      end else if (rtc && !rtc_seen_q) begin
         cnt32_q <= timer_pkg::RTC_START;
      end else if (join32 && wr_aload) begin
         cnt32_q <= bus_req.wdata;
      end else if (join32 && run32) begin
         // R18: down count, reload after zero
         cnt32_q <= (cnt32_q == 32'h0000_0000) ? {bload_q, aload_q} : cnt32_q - 32'h0000_0001;
      end else if (rtc && actl_q.run && rtc_tick) begin
         // R12: up count, roll over on match
         cnt32_q <= rtc_hit ? 32'h0000_0000 : cnt32_q + 32'h0000_0001;
      end
   end

   // ***************************************
   // the two halves
   // ***************************************
   // R1: two halves or one joined counter
   // R4: halves live only in split mode
   half_counter u_half_a (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .active(split),
      .mode(amode_q),
      .en(actl_q.run),
      .stall(actl_q.stall),
      .pwm_inv(actl_q.pwm_inv),
      .edge_hit(edge_hit[0]),
      .load_wr(wr_aload & split),
      .load(wr_aload ? bus_req.wdata[15:0] : aload_q),
      .match(amatch_q),
      .pre(apre_q),
      .count(a_cnt),
      .capture(a_cap),
      .timeout(a_to),
      .event_hit(a_ev),
      .done(a_done_h),
      .pwm(a_pwm)
   );

   half_counter u_half_b (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .active(split),
      .mode(bmode_q),
      .en(bctl_q.run),
      .stall(bctl_q.stall),
      .pwm_inv(bctl_q.pwm_inv),
      .edge_hit(edge_hit[1]),
      .load_wr(wr_bload & split),
      .load(wr_bload ? bus_req.wdata[15:0] : bload_q),
      .match(bmatch_q),
      .pre(bpre_q),
      .count(b_cnt),
      .capture(b_cap),
      .timeout(b_to),
      .event_hit(b_ev),
      .done(b_done),
      .pwm(b_pwm)
   );

   // R19: joined one-shot stop
   assign a_done = a_done_h | (to32 & amode_q.tmr == timer_pkg::TMR_ONESHOT);

   // ***************************************
   // status, pins, trigger
   // ***************************************
   // R18: time-out flags, set beats clear
   assign st_set = {rtc_hit, b_ev, b_to, a_ev, a_to | to32};
   assign st_clr = (bus_req.we && bus_req.addr == timer_pkg::OFF_STATUS) ? bus_req.wdata[4:0] : 5'h00;
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         status_q <= 5'h00;
      end else begin
         status_q <= (status_q & ~st_clr) | st_set;
      end
   end

   // R5: odd pin only in split mode
   assign ccp_oe = {split & bmode_q.pwm, split & amode_q.pwm};
   assign ccp_out = {b_pwm, a_pwm};

   // R20: one-cycle trigger at zero
   // R11: trigger sources ORed
   assign adc_trig = ((a_to | to32) & actl_q.trig_en) | (b_to & bctl_q.trig_en);

   // ***************************************
   // register read port
   // ***************************************
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rdata_q <= 32'h0000_0000;
      end else if (bus_req.re) begin
         case (bus_req.addr)
            timer_pkg::OFF_CFG: rdata_q <= {29'h0, cfg_q};
            timer_pkg::OFF_AMODE: rdata_q <= {28'h0, amode_q};
            timer_pkg::OFF_BMODE: rdata_q <= {28'h0, bmode_q};
            timer_pkg::OFF_CTL: rdata_q <= {18'h0, bctl_q, 2'h0, actl_q};
            timer_pkg::OFF_STATUS: rdata_q <= {27'h0, status_q};
            timer_pkg::OFF_ALOAD: rdata_q <= split ? {16'h0, aload_q} : {bload_q, aload_q};
            timer_pkg::OFF_BLOAD: rdata_q <= {16'h0, bload_q};
            timer_pkg::OFF_AMATCH: rdata_q <= {16'h0, amatch_q};
            timer_pkg::OFF_BMATCH: rdata_q <= {16'h0, bmatch_q};
            timer_pkg::OFF_APRE: rdata_q <= {24'h0, apre_q};
            timer_pkg::OFF_BPRE: rdata_q <= {24'h0, bpre_q};
            // R7: joined count read
            timer_pkg::OFF_ACOUNT: rdata_q <= !split ? cnt32_q :
                                   {16'h0, (amode_q.edge_time ? a_cap : a_cnt)};
            timer_pkg::OFF_BCOUNT: rdata_q <= !split ? {16'h0, cnt32_q[31:16]} :
                                   {16'h0, (bmode_q.edge_time ? b_cap : b_cnt)};
            default: rdata_q <= 32'h0000_0000;
         endcase
      end else begin
         rdata_q <= 32'h0000_0000;
      end
   end
   assign rdata = rdata_q;

   // ***************************************
   // checks
   // ***************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   a_oneshot_stop: assert property (to32 && amode_q.tmr == timer_pkg::TMR_ONESHOT && !wr_ctl |=> !actl_q.run) // R19
      else $error("one-shot did not clear run");
   a_zero_reload: assert property (to32 && !wr_aload |=> cnt32_q == $past({bload_q, aload_q})) // R18
      else $error("joined counter did not reload");
   a_down_step: assert property (join32 && run32 && cnt32_q != 0 && !wr_aload |=> cnt32_q == $past(cnt32_q) - 1) // R18
      else $error("joined counter did not step down");
   a_stall_hold: assert property (join32 && actl_q.stall && !wr_aload ##1 join32 |-> $stable(cnt32_q)) // R13
      else $error("stalled counter moved");
   a_rtc_roll: assert property (rtc_hit ##1 rtc |-> cnt32_q == 32'h0000_0000) // R12
      else $error("rtc did not roll over");
   a_reserved_idle: assert property (mode == timer_pkg::MODE_IDLE [*2] |-> $stable(cnt32_q) && $stable(a_cnt)) // R21
      else $error("counter moved in reserved mode");
   a_odd_pin_off: assert property (!split |-> ccp_oe[1] == 1'b0) // R5
      else $error("odd pin driven in joined mode");
   a_wide_read: assert property (bus_req.re && bus_req.addr == timer_pkg::OFF_ACOUNT && !split
      |=> rdata == $past(cnt32_q)) // R7
      else $error("joined count read wrong");
   a_wide_load: assert property (wr_aload && !split |=> bload_q == $past(bus_req.wdata[31:16])) // R6
      else $error("upper load half lost");
   a_trig_pulse: assert property (adc_trig && join32 && {bload_q, aload_q} != 0 && !wr_aload |=> !adc_trig) // R20
      else $error("trigger longer than one cycle");

   c_oneshot_done: cover property (to32 && amode_q.tmr == timer_pkg::TMR_ONESHOT);
   c_rtc_match: cover property (rtc_hit);
   c_edge_done: cover property (split && a_done_h && !amode_q.pwm);
   c_pwm_toggle: cover property (split && $rose(ccp_out[0]));
endmodule
`default_nettype wire

// File: half_counter.sv
// one 16-bit counter half: timer with prescaler, edge count, edge time, pwm
// assumes edge_hit is a one-cycle pulse already qualified by edge type
`timescale 1ns/100ps
`default_nettype none
module half_counter (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic active,
   input wire timer_pkg::half_mode_t mode,
   input wire logic en,
   input wire logic stall,
   input wire logic pwm_inv,
   input wire logic edge_hit,
   input wire logic load_wr,
   input wire logic [15:0] load,
   input wire logic [15:0] match,
   input wire logic [7:0] pre,
   output logic [15:0] count,
   output logic [15:0] capture,
   output logic timeout,
   output logic event_hit,
   output logic done,
   output logic pwm
);
   logic [7:0] pre_q;
   logic [15:0] cnt_q;
   logic [15:0] cap_q;
   logic pwm_q;
   logic run;
   logic is_timer;
   logic is_cnt;
   logic is_time;
   logic tick;

   assign run = active & en & ~stall;
   assign is_timer = ~mode.pwm & (mode.tmr == timer_pkg::TMR_ONESHOT || mode.tmr == timer_pkg::TMR_PERIODIC);
   assign is_cnt = ~mode.pwm & (mode.tmr == timer_pkg::TMR_CAPTURE) & ~mode.edge_time;
   assign is_time = ~mode.pwm & (mode.tmr == timer_pkg::TMR_CAPTURE) & mode.edge_time;
   assign tick = (pre_q == 8'h00);

   // ***************************************
   // prescaler
   // ***************************************
   // R10: prescale resets zero
   // R14: prescale stretch
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pre_q <= timer_pkg::PRE_RST;
      end else if (run & is_timer) begin
         pre_q <= (tick || cnt_q == 16'h0000) ? pre : pre_q - 8'h01;
      end
   end

   // ***************************************
   // counter
   // ***************************************
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= timer_pkg::COUNT_RST;
      end else if (load_wr) begin
         cnt_q <= load;
      end else if (run) begin
         if (is_timer || mode.pwm || is_time) begin
            // R14: down count, reload
            if (cnt_q == 16'h0000) begin
               cnt_q <= load;
            end else if (tick || !is_timer) begin
               cnt_q <= cnt_q - 16'h0001;
            end
         end else if (is_cnt) begin
            // R15: edge count down
            if (cnt_q == match) begin
               cnt_q <= load;
            end else if (edge_hit) begin
               cnt_q <= cnt_q - 16'h0001;
            end
         end
      end
   end

   // R15: edge time capture
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cap_q <= 16'h0000;
      end else if (run & is_time & edge_hit) begin
         cap_q <= cnt_q;
      end
   end

   // R16: pwm with inversion
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pwm_q <= 1'b0;
      end else begin
         pwm_q <= (active & en & mode.pwm) ? ((cnt_q > match) ^ pwm_inv) : pwm_inv;
      end
   end

   assign count = cnt_q;
   assign capture = cap_q;
   assign pwm = pwm_q;
   assign timeout = run & (is_timer | mode.pwm) & (cnt_q == 16'h0000);
   assign event_hit = run & ((is_cnt & cnt_q == match) | (is_time & edge_hit));
   assign done = run & ((is_timer & mode.tmr == timer_pkg::TMR_ONESHOT & cnt_q == 16'h0000) | (is_cnt & cnt_q == match));
endmodule
`default_nettype wire

// File: test_dual_half_timer_core.sv
// self-checking bench of the dual half timer core
// assumes timer_pins as the far side and a 10 MHz sys_clk
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin n_fail++; $display("[ERR] %s exp %h got %h", nm, e, a); end end
module test_dual_half_timer_core;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   timer_pkg::bus_req_t req = '0;
   logic [31:0] rdata;
   logic [1:0] ccp_in;
   logic [1:0] ccp_out;
   logic [1:0] ccp_oe;
   logic adc_trig;
   int n_fail = 0;
   int n_checks = 0;
   int seed = 20380;
   int t0;
   logic [31:0] d;
   logic [31:0] e;
   logic [31:0] ld;
   dual_half_timer_core #(.RTC_DIV(4)) i_dut (.sys_clk(sys_clk), .resetn(resetn), .bus_req(req),
      .rdata(rdata), .ccp_in(ccp_in), .ccp_out(ccp_out), .ccp_oe(ccp_oe), .adc_trig(adc_trig));
   timer_pins i_pins (.sys_clk(sys_clk), .ccp_out(ccp_out), .ccp_oe(ccp_oe), .adc_trig(adc_trig),
      .ccp_in(ccp_in));
   initial forever #50 sys_clk = ~sys_clk;
   function automatic int period(input logic [31:0] load);
      return int'(load) + 1;
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge sys_clk) req <= '{addr: a, wdata: v, we: 1'b1, re: 1'b0};
      @(posedge sys_clk) req.we <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge sys_clk) req <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1};
      @(posedge sys_clk) req.re <= 1'b0;
      @(negedge sys_clk) v = rdata;
   endtask
   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
      logic [31:0] v;
      rd(a, v);
      `CHK(nm, ex, v)
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // hang guard, about twenty-five times the expected run
   initial begin
      #1000000;
      n_fail++;
      give_verdict();
   end
   initial begin
      repeat (6) @(posedge sys_clk);
      resetn <= 1'b1;
      rchk("cfg", timer_pkg::OFF_CFG, 32'h0);
      rchk("ctl", timer_pkg::OFF_CTL, 32'h0);
      rchk("load", timer_pkg::OFF_ALOAD, 32'hFFFF_FFFF);
      rchk("count", timer_pkg::OFF_ACOUNT, 32'hFFFF_FFFF);
      rchk("pre_a", timer_pkg::OFF_APRE, 32'h0);
      rchk("pre_b", timer_pkg::OFF_BPRE, 32'h0);
      rchk("unmapped", 8'h50, 32'h0);
      $display("reset test done");
      e = $random(seed);
      wr(timer_pkg::OFF_ALOAD, e);
      rchk("bload", timer_pkg::OFF_BLOAD, {16'h0, e[31:16]});
      rchk("count32", timer_pkg::OFF_ACOUNT, e);
      rchk("count_hi", timer_pkg::OFF_BCOUNT, {16'h0, e[31:16]});
      ld = 32'h2 + ($unsigned($random(seed)) % 4);
      wr(timer_pkg::OFF_AMODE, timer_pkg::TMR_PERIODIC);
      wr(timer_pkg::OFF_ALOAD, ld);
      wr(timer_pkg::OFF_CTL, 32'h11);
      t0 = i_pins.n_trig;
      repeat (6 * period(ld) + 2) @(posedge sys_clk);
      `CHK("trig", 6, i_pins.n_trig - t0)
      wr(timer_pkg::OFF_CTL, 32'h0);
      rchk("timeout", timer_pkg::OFF_STATUS, 32'h1);
      wr(timer_pkg::OFF_STATUS, 32'h1);
      rchk("w1c", timer_pkg::OFF_STATUS, 32'h0);
      wr(timer_pkg::OFF_ALOAD, 32'h100);
      wr(timer_pkg::OFF_CTL, 32'h3);
      rd(timer_pkg::OFF_ACOUNT, d);
      rchk("stall", timer_pkg::OFF_ACOUNT, d);
      wr(timer_pkg::OFF_CTL, 32'h1);
      rd(timer_pkg::OFF_ACOUNT, e);
      `CHK("unstall", 1'b1, e < d)
      wr(timer_pkg::OFF_CTL, 32'h0);
      wr(timer_pkg::OFF_AMODE, timer_pkg::TMR_ONESHOT);
      wr(timer_pkg::OFF_ALOAD, ld);
      wr(timer_pkg::OFF_CTL, 32'h1);
      repeat (period(ld) + 4) @(posedge sys_clk);
      rchk("oneshot", timer_pkg::OFF_CTL, 32'h0);
      rchk("reload", timer_pkg::OFF_ACOUNT, ld);
      $display("joined test done");
      // reserved selects: 2 or 3
      wr(timer_pkg::OFF_CFG, 32'h2 + ($unsigned($random(seed)) % 2));
      wr(timer_pkg::OFF_CTL, 32'h1);
      rd(timer_pkg::OFF_ACOUNT, d);
      repeat (5) @(posedge sys_clk);
      rchk("idle", timer_pkg::OFF_ACOUNT, d);
      wr(timer_pkg::OFF_CTL, 32'h0);
      wr(timer_pkg::OFF_CFG, timer_pkg::CFG_SPLIT16);
      e = $random(seed);
      wr(timer_pkg::OFF_APRE, e[7:0]);
      rchk("pre", timer_pkg::OFF_APRE, e[7:0]);
      wr(timer_pkg::OFF_APRE, 32'h0);
      wr(timer_pkg::OFF_BMATCH, e[31:16]);
      rchk("match", timer_pkg::OFF_BMATCH, e[31:16]);
      wr(timer_pkg::OFF_BMODE, timer_pkg::TMR_PERIODIC);
      wr(timer_pkg::OFF_ALOAD, ld);
      wr(timer_pkg::OFF_BLOAD, ld);
      wr(timer_pkg::OFF_STATUS, 32'h1F);
      wr(timer_pkg::OFF_CTL, 32'h101);
      repeat (period(ld) + 4) @(posedge sys_clk);
      rchk("split_ctl", timer_pkg::OFF_CTL, 32'h100);
      rchk("split_st", timer_pkg::OFF_STATUS, 32'h5);
      rchk("a_reload", timer_pkg::OFF_ACOUNT, ld);
      wr(timer_pkg::OFF_CTL, 32'h0);
      wr(timer_pkg::OFF_BMODE, timer_pkg::TMR_CAPTURE);
      wr(timer_pkg::OFF_BLOAD, 32'h4);
      wr(timer_pkg::OFF_BMATCH, 32'h2);
      wr(timer_pkg::OFF_STATUS, 32'h1F);
      wr(timer_pkg::OFF_CTL, 32'h100);
      i_pins.pulse(1, 2);
      rchk("edge_st", timer_pkg::OFF_STATUS, 32'h8);
      rchk("edge_run", timer_pkg::OFF_CTL, 32'h0);
      wr(timer_pkg::OFF_AMODE, 32'hA);
      wr(timer_pkg::OFF_CTL, 32'h20);
      repeat (2) @(posedge sys_clk);
      `CHK("pwm_oe", 1'b1, ccp_oe[0])
      `CHK("pwm_inv", 1'b1, ccp_out[0])
      $display("split test done");
      wr(timer_pkg::OFF_CTL, 32'h0);
      wr(timer_pkg::OFF_CFG, timer_pkg::CFG_RTC);
      wr(timer_pkg::OFF_AMATCH, 32'h40);
      wr(timer_pkg::OFF_BMATCH, 32'h0);
      rchk("rtc_start", timer_pkg::OFF_ACOUNT, timer_pkg::RTC_START);
      wr(timer_pkg::OFF_CTL, 32'h3);
      i_pins.rtc_on <= 1'b1;
      repeat (120) @(posedge sys_clk);
      i_pins.rtc_on <= 1'b0;
      rd(timer_pkg::OFF_ACOUNT, d);
      `CHK("rtc_runs", 1'b1, d > timer_pkg::RTC_START)
      wr(timer_pkg::OFF_AMATCH, d + 32'h1);
      i_pins.rtc_on <= 1'b1;
      repeat (72) @(posedge sys_clk);
      i_pins.rtc_on <= 1'b0;
      rd(timer_pkg::OFF_STATUS, e);
      `CHK("rtc_match", 1'b1, e[timer_pkg::ST_RTC])
      $display("rtc test done");
      give_verdict();
   end
endmodule
`default_nettype wire

// File: timer_pins.sv
// far side of the timer pins: event sources and converter trigger sink
// assumes the core samples its pins on sys_clk rising edges
`timescale 1ns/100ps
`default_nettype none
module timer_pins (
   input wire logic sys_clk,
   input wire logic [1:0] ccp_out,
   input wire logic [1:0] ccp_oe,
   input wire logic adc_trig,
   output logic [1:0] ccp_in
);
   logic [1:0] drv = 2'h0;
   logic rtc_on = 1'b0;
   int n_trig = 0;
   int div = 0;
   // wire level: the core wins while its enable is high
   assign ccp_in = (ccp_oe & ccp_out) | (~ccp_oe & drv);
   always @(posedge sys_clk) if (adc_trig === 1'b1) n_trig++;
   // slow clock on the even pin, still when off
   always @(posedge sys_clk) if (rtc_on) begin
      div = (div + 1) % 3;
      if (div == 0) drv[0] <= ~drv[0];
   end
   task automatic pulse(input int pin, input int n);
      repeat (n) begin
         @(posedge sys_clk) drv[pin] <= 1'b1;
         repeat (2) @(posedge sys_clk);
         drv[pin] <= 1'b0;
         repeat (2) @(posedge sys_clk);
      end
   endtask
endmodule
`default_nettype wire

// File: timer_pkg.sv
// constants, types and register map of the dual half timer
// assumes a single 10 MHz system clock and a plain register port
package timer_pkg;

   // ***************************************
   // register offsets (byte addresses)
   // ***************************************
   localparam logic [7:0] OFF_CFG = 8'h00;
   localparam logic [7:0] OFF_AMODE = 8'h04;
   localparam logic [7:0] OFF_BMODE = 8'h08;
   localparam logic [7:0] OFF_CTL = 8'h0C;
   localparam logic [7:0] OFF_STATUS = 8'h1C;
   localparam logic [7:0] OFF_ALOAD = 8'h28;
   localparam logic [7:0] OFF_BLOAD = 8'h2C;
   localparam logic [7:0] OFF_AMATCH = 8'h30;
   localparam logic [7:0] OFF_BMATCH = 8'h34;
   localparam logic [7:0] OFF_APRE = 8'h38;
   localparam logic [7:0] OFF_BPRE = 8'h3C;
   localparam logic [7:0] OFF_ACOUNT = 8'h48;
   localparam logic [7:0] OFF_BCOUNT = 8'h4C;

   // ***************************************
   // encodings and field positions
   // ***************************************
   localparam logic [2:0] CFG_JOIN32 = 3'h0;
   localparam logic [2:0] CFG_RTC = 3'h1;
   localparam logic [2:0] CFG_SPLIT16 = 3'h4;
   localparam logic [1:0] TMR_ONESHOT = 2'h1;
   localparam logic [1:0] TMR_PERIODIC = 2'h2;
   localparam logic [1:0] TMR_CAPTURE = 2'h3;
   localparam logic [1:0] EVT_RISE = 2'h0;
   localparam logic [1:0] EVT_FALL = 2'h1;
   localparam logic [1:0] EVT_BOTH = 2'h3;
   localparam int CTL_B_LSB = 8;
   localparam int ST_A_TO = 0;
   localparam int ST_A_EV = 1;
   localparam int ST_B_TO = 2;
   localparam int ST_B_EV = 3;
   localparam int ST_RTC = 4;

   // ***************************************
   // reset values and rates
   // ***************************************
   localparam logic [15:0] LOAD_RST = 16'hFFFF;
   localparam logic [15:0] COUNT_RST = 16'hFFFF;
   localparam logic [7:0] PRE_RST = 8'h00;
   localparam logic [31:0] RTC_START = 32'h0000_0001;
   localparam int RTC_IN_HZ = 32768;
   localparam int RTC_OUT_HZ = 1;
   localparam int RTC_DIV = RTC_IN_HZ / RTC_OUT_HZ;

   typedef enum logic [3:0] {
      MODE_IDLE = 4'h1,
      MODE_JOIN32 = 4'h2,
      MODE_RTC = 4'h4,
      MODE_SPLIT16 = 4'h8
   } block_mode_t;

   typedef struct packed {
      logic pwm;
      logic edge_time;
      logic [1:0] tmr;
   } half_mode_t;

   typedef struct packed {
      logic pwm_inv;
      logic trig_en;
      logic [1:0] evt;
      logic stall;
      logic run;
   } half_ctl_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic we;
      logic re;
   } bus_req_t;

endpackage
